//--- sfts_pkg.sv
// shared constants and types of the supply fault timing supervisor
// assumes one 10 MHz free-running timebase feeds every counter
package sfts_pkg;

  // timebase period
  localparam int unsigned CLK_PERIOD_NS = 100;

  // nominal times as specified
  localparam int unsigned OV_DEB_NS     = 6000;          // overvoltage debounce, 6 us
  localparam int unsigned UV12_DEB_NS   = 6000;          // +/-12 V undervoltage debounce, 6 us
  localparam int unsigned UV5_DEB_US    = 450;           // 5 V / 3.3 V / aux undervoltage, 450 us
  localparam int unsigned BLANK_MS      = 64;            // undervoltage blanking, 64 ms
  localparam int unsigned PG_DELAY_MS   = 250;           // power-good delay, 250 ms
  localparam int unsigned PSON_DELAY_US = 2500;          // request-to-fault delay, 2.5 ms
  localparam int unsigned PSON_DEB_MS   = 75;            // request debounce, 75 ms
  localparam int unsigned SS_PERIOD_US  = 8000;          // soft-start ramp, 8 ms
  localparam int unsigned RETRY_MS      = 1000;          // bounce-mode restart wait, 1 s

  // soft-start staircase: 2.5 V in roughly 39 mV steps
  localparam int unsigned SS_STEPS      = 64;
  localparam int unsigned SS_W          = 7;
  localparam logic [SS_W-1:0] SS_CODE_RST = 7'h00;
  localparam logic [SS_W-1:0] SS_CODE_TOP = 7'h40;

  // derived cycle counts; the two 6 us debounce figures rounded up, the rest truncated
  localparam int unsigned OV_DEB_CYC     = (OV_DEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned UV12_DEB_CYC   = (UV12_DEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned UV5_DEB_CYC    = UV5_DEB_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned BLANK_CYC      = BLANK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned PG_DELAY_CYC   = PG_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned PSON_DELAY_CYC = PSON_DELAY_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned PSON_DEB_CYC   = PSON_DEB_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned SS_STEP_CYC    = SS_PERIOD_US * 1000 / CLK_PERIOD_NS / SS_STEPS;
  localparam int unsigned RETRY_CYC      = RETRY_MS * 1000000 / CLK_PERIOD_NS;

  // reset values of the outputs
  localparam logic MAIN_FAULT_RST = 1'b1;  // converter held off
  localparam logic AUX_FAULT_RST  = 1'b0;
  localparam logic PG_RST         = 1'b0;
  localparam logic REQ_RST        = 1'b1;  // request taken as "off" until debounced

  // comparator results, high means the condition is present
  typedef struct packed {
    logic ov_main;   // any main rail overvoltage
    logic uv_12;     // +12 V or -12 V undervoltage
    logic uv_5v3;    // +5 V or 3.3 V undervoltage
    logic aux_ov;    // auxiliary rail overvoltage
    logic aux_uv;    // auxiliary rail undervoltage
  } sfts_cmp_t;

  // main converter control states
  typedef enum logic [2:0] {
    SFTS_OFF   = 3'b000,
    SFTS_START = 3'b001,
    SFTS_RUN   = 3'b010,
    SFTS_FAULT = 3'b011,
    SFTS_RETRY = 3'b100
  } sfts_state_t;

endpackage

//--- sfts_persist.sv
// persistence filter: output follows the input once it has held for CYCLES
// assumes inputs synchronous to ref_clk; clr is a synchronous restart
`timescale 1ns/1ps
`default_nettype none
module sfts_persist #(
  parameter int unsigned CYCLES    = 60,
  parameter bit          BOTH_WAYS = 1'b1,  // 0: a fall passes at once
  parameter bit          RST_VAL   = 1'b0
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic clk_en,
  // control
  input  wire logic clr,
  // level
  input  wire logic level_in,
  output logic      level_out
);
  localparam int unsigned CW = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_bad_cycles
    $error("sfts_persist needs CYCLES of at least one");
  end

  logic [CW-1:0] cnt_r, cnt_nxt;   // cycles the input has differed
  logic          lvl_r, lvl_nxt;   // accepted level

  // next state: count while input disagrees, accept on the last cycle
  always_comb begin
    cnt_nxt = cnt_r;
    lvl_nxt = lvl_r;
    if (clr) begin
      cnt_nxt = '0;
      lvl_nxt = RST_VAL;
    end else if (level_in == lvl_r) begin
      cnt_nxt = '0;  // a glitch restarts the count
    end else if (!BOTH_WAYS && !level_in) begin
      cnt_nxt = '0;
      lvl_nxt = 1'b0;
    end else if (cnt_r == CW'(CYCLES - 1)) begin
      cnt_nxt = '0;
      lvl_nxt = level_in;
    end else begin
      cnt_nxt = cnt_r + CW'(1);
    end
  end

  // registers only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      lvl_r <= RST_VAL;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_out = lvl_r;
endmodule
`default_nettype wire

//--- sfts_top.sv
// supply fault timing supervisor: debounce, blanking, delays and soft start
// assumes comparator results and pins already synchronous to ref_clk
// How it works
// - main overvoltage debounced 6 us before main fault
// - main undervoltage debounced 6 us or 450 us
// - aux overvoltage debounced 6 us before aux fault
// - aux undervoltage debounced 450 us before aux fault
// - aux undervoltage ignored 64 ms after start-up
// - main undervoltage ignored 64 ms after mains sense
// - power good rises 250 ms after rails good in the run state
// - main fault follows accepted request after 2.5 ms
// - request change accepted after holding 75 ms
// - reference ramps in 64 steps over 8 ms
// - request high keeps main fault released high
// - aux fault latches high on aux overvoltage or unblanked aux undervoltage
// - undervoltage either latches or retries after 1 s
`timescale 1ns/1ps
`default_nettype none
module sfts_top
  import sfts_pkg::*;
#(
  parameter int unsigned UV5_DEB   = sfts_pkg::UV5_DEB_CYC,
  parameter int unsigned BLANK     = sfts_pkg::BLANK_CYC,
  parameter int unsigned PG_DELAY  = sfts_pkg::PG_DELAY_CYC,
  parameter int unsigned PSON_DLY  = sfts_pkg::PSON_DELAY_CYC,
  parameter int unsigned PSON_DEB  = sfts_pkg::PSON_DEB_CYC,
  parameter int unsigned SS_STEP   = sfts_pkg::SS_STEP_CYC,
  parameter int unsigned RETRY     = sfts_pkg::RETRY_CYC
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic                  clk_en,
  // supply and mode
  input  wire logic                  supply_ok_in,     // supply above start-up threshold
  input  wire logic                  bounce_mode_in,   // 1: retry, 0: latch
  // sensing
  input  wire sfts_pkg::sfts_cmp_t   cmp_in,
  input  wire logic                  mains_sense_in,
  // host
  input  wire logic                  supply_on_request, // low asks for power
  output logic                       power_good_out,
  // converter controls
  output logic                       main_fault_out,
  output logic                       aux_fault_out,
  output logic [sfts_pkg::SS_W-1:0]  soft_start_code
);
  import sfts_pkg::*;

  localparam int unsigned SSW = $clog2(SS_STEP + 1);
  localparam int unsigned RTW = $clog2(RETRY + 1);

  if (RETRY < 1 || SS_STEP < 1) begin : g_bad_cfg
    $error("sfts_top needs non-zero retry and step counts");
  end

  // every timer restarts while the supply sits below threshold
  logic clr;
  assign clr = !supply_ok_in;

  // debounced comparator results
  logic ov_main_d, uv12_d, uv5_d, aux_ov_d, aux_uv_d;
  // blanking and delay results
  logic aux_uv_live, main_uv_live, req_deb, req_off_dly, rails_good_dly;
  logic rails_good;  // raw main undervoltage comparators all good
  // declared early: the power-good filter below qualifies on the run state
  sfts_state_t state_r, state_nxt;  // main converter control state

  // main overvoltage filter
  sfts_persist #(.CYCLES(OV_DEB_CYC), .BOTH_WAYS(1'b0), .RST_VAL(1'b0)) u_ov_main (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .clr(clr),
    .level_in(cmp_in.ov_main), .level_out(ov_main_d));
  // +/-12 V undervoltage filter
  sfts_persist #(.CYCLES(UV12_DEB_CYC), .BOTH_WAYS(1'b0), .RST_VAL(1'b0)) u_uv12 (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .clr(clr),
    .level_in(cmp_in.uv_12), .level_out(uv12_d));
  // 5 V and 3.3 V undervoltage filter
  sfts_persist #(.CYCLES(UV5_DEB), .BOTH_WAYS(1'b0), .RST_VAL(1'b0)) u_uv5 (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .clr(clr),
    .level_in(cmp_in.uv_5v3), .level_out(uv5_d));
  // auxiliary overvoltage filter
  sfts_persist #(.CYCLES(OV_DEB_CYC), .BOTH_WAYS(1'b0), .RST_VAL(1'b0)) u_aux_ov (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .clr(clr),
    .level_in(cmp_in.aux_ov), .level_out(aux_ov_d));
  // auxiliary undervoltage filter
  sfts_persist #(.CYCLES(UV5_DEB), .BOTH_WAYS(1'b0), .RST_VAL(1'b0)) u_aux_uv (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .clr(clr),
    .level_in(cmp_in.aux_uv), .level_out(aux_uv_d));

  // aux blanking runs once from the supply reaching its threshold
  sfts_persist #(.CYCLES(BLANK), .BOTH_WAYS(1'b0), .RST_VAL(1'b0)) u_aux_blank (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .clr(clr),
    .level_in(1'b1), .level_out(aux_uv_live));
  // main blanking restarts whenever mains sense drops
  sfts_persist #(.CYCLES(BLANK), .BOTH_WAYS(1'b0), .RST_VAL(1'b0)) u_main_blank (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .clr(clr),
    .level_in(mains_sense_in), .level_out(main_uv_live));

  // request debounce, both edges must hold
  sfts_persist #(.CYCLES(PSON_DEB), .BOTH_WAYS(1'b1), .RST_VAL(REQ_RST)) u_req_deb (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .clr(clr),
    .level_in(supply_on_request), .level_out(req_deb));
  // accepted request reaches the main converter after a fixed delay
  sfts_persist #(.CYCLES(PSON_DLY), .BOTH_WAYS(1'b1), .RST_VAL(REQ_RST)) u_req_dly (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .clr(clr),
    .level_in(req_deb), .level_out(req_off_dly));

  // power-good delay; any main undervoltage drops it at once
  assign rails_good = !cmp_in.uv_12 && !cmp_in.uv_5v3;
  sfts_persist #(.CYCLES(PG_DELAY), .BOTH_WAYS(1'b0), .RST_VAL(1'b0)) u_pg_dly (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .clr(clr),
    .level_in(rails_good && state_r == SFTS_RUN), .level_out(rails_good_dly));

  // soft start, retry wait and outputs
  logic [SS_W-1:0] ss_r, ss_nxt;          // soft-start reference code
  logic [SSW-1:0]  step_r, step_nxt;      // cycles within one step
  logic [RTW-1:0]  retry_r, retry_nxt;    // bounce-mode wait
  logic            mf_r, mf_nxt;
  logic            af_r, af_nxt;
  logic            pg_r, pg_nxt;
  logic            main_trip;             // debounced main fault condition

  // undervoltage only counts once its blanking has ended
  assign main_trip = ov_main_d || (main_uv_live && (uv12_d || uv5_d));

  // next state of the main converter control
  always_comb begin
    state_nxt = state_r;
    ss_nxt    = ss_r;
    step_nxt  = step_r;
    retry_nxt = retry_r;
    case (state_r)
      // held off until the delayed request goes low
      SFTS_OFF: begin
        ss_nxt   = SS_CODE_RST;
        step_nxt = '0;
        if (!req_off_dly) begin
          state_nxt = SFTS_START;
        end
      end
      // staircase ramp of the reference
      SFTS_START, SFTS_RUN: begin
        if (req_off_dly) begin
          state_nxt = SFTS_OFF;
        end else if (main_trip) begin
          state_nxt = SFTS_FAULT;
        end else if (ss_r == SS_CODE_TOP) begin
          state_nxt = SFTS_RUN;
        end else if (step_r == SSW'(SS_STEP - 1)) begin
          step_nxt = '0;
          ss_nxt   = ss_r + SS_W'(1);
        end else begin
          step_nxt = step_r + SSW'(1);
        end
      end
      // latched unless bounce mode is selected
      SFTS_FAULT: begin
        ss_nxt    = SS_CODE_RST;
        step_nxt  = '0;
        retry_nxt = '0;
        if (bounce_mode_in && !ov_main_d) begin
          state_nxt = SFTS_RETRY;
        end
      end
      // wait before trying the converter again
      SFTS_RETRY: begin
        if (req_off_dly) begin
          state_nxt = SFTS_OFF;
        end else if (retry_r == RTW'(RETRY - 1)) begin
          state_nxt = SFTS_START;
        end else begin
          retry_nxt = retry_r + RTW'(1);
        end
      end
      default: begin
        state_nxt = SFTS_OFF;
      end
    endcase
  end

  // next values of the three fault and good outputs
  always_comb begin
    // request high or any fault state: released high, converter off
    mf_nxt = (state_nxt == SFTS_OFF) || (state_nxt == SFTS_FAULT) ||
             (state_nxt == SFTS_RETRY);
    // aux fault holds once set; cleared only by a restart
    af_nxt = af_r || aux_ov_d || (aux_uv_live && aux_uv_d);
    if (aux_ov_d) begin
      af_nxt = 1'b1;
    end
    // good only while running, delayed, and nothing is faulted
    pg_nxt = rails_good_dly && (state_nxt == SFTS_RUN) && !af_nxt &&
             !main_trip;
  end

  // registers only; below threshold everything returns to reset values
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= SFTS_OFF;
      ss_r    <= SS_CODE_RST;
      step_r  <= '0;
      retry_r <= '0;
      mf_r    <= MAIN_FAULT_RST;
      af_r    <= AUX_FAULT_RST;
      pg_r    <= PG_RST;
    end else if (clk_en) begin
      if (clr) begin
        state_r <= SFTS_OFF;
        ss_r    <= SS_CODE_RST;
        step_r  <= '0;
        retry_r <= '0;
        mf_r    <= MAIN_FAULT_RST;
        af_r    <= AUX_FAULT_RST;
        pg_r    <= PG_RST;
      end else begin
        state_r <= state_nxt;
        ss_r    <= ss_nxt;
        step_r  <= step_nxt;
        retry_r <= retry_nxt;
        mf_r    <= mf_nxt;
        af_r    <= af_nxt;
        pg_r    <= pg_nxt;
      end
    end
  end

  // outputs straight from flip-flops
  assign main_fault_out  = mf_r;
  assign aux_fault_out   = af_r;
  assign power_good_out  = pg_r;
  assign soft_start_code = ss_r;
endmodule
`default_nettype wire

//--- sfts_monitor.sv
// assertion checker for the supply fault timing supervisor outputs
// assumes it is bound to sfts_top and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module sfts_monitor
  import sfts_pkg::*;
#(
  parameter int unsigned PSON_DLY = 30,
  parameter int unsigned PSON_DEB = 80
) (
  // clock and reset
  input wire logic                      ref_clk,
  input wire logic                      resetn,
  input wire logic                      clk_en,
  // causes
  input wire logic                      supply_ok_in,
  input wire sfts_pkg::sfts_cmp_t       cmp_in,
  input wire logic                      supply_on_request,
  // effects
  input wire logic                      power_good_out,
  input wire logic                      main_fault_out,
  input wire logic                      aux_fault_out,
  input wire logic [sfts_pkg::SS_W-1:0] soft_start_code
);
  logic        run;                 // timers may advance
  logic [19:0] lo_r, hi_r, ov_r, ao_r;
  logic [19:0] lo_nxt, hi_nxt, ov_nxt, ao_nxt;
  assign run = clk_en & supply_ok_in;
  // consecutive sampled cycles of each cause; 20 bits outlast the run
  always_comb begin
    lo_nxt = (run && !supply_on_request) ? lo_r + 20'h1 : 20'h0;
    hi_nxt = (run && supply_on_request) ? hi_r + 20'h1 : 20'h0;
    ov_nxt = (run && cmp_in.ov_main) ? ov_r + 20'h1 : 20'h0;
    ao_nxt = (run && cmp_in.aux_ov) ? ao_r + 20'h1 : 20'h0;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {lo_r, hi_r, ov_r, ao_r} <= '0;
    end else begin
      {lo_r, hi_r, ov_r, ao_r} <= {lo_nxt, hi_nxt, ov_nxt, ao_nxt};
    end
  end
  a_clear_low: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en && !supply_ok_in |=> main_fault_out && !aux_fault_out && !power_good_out
    && soft_start_code == SS_CODE_RST) else $error("outputs not cleared");
  a_code_top: assert property (@(posedge ref_clk) disable iff (!resetn)
    soft_start_code <= SS_CODE_TOP) else $error("reference code past top");
  a_code_step: assert property (@(posedge ref_clk) disable iff (!resetn)
    $changed(soft_start_code) |-> soft_start_code == $past(soft_start_code) + 7'h01
    || soft_start_code == SS_CODE_RST) else $error("reference code jumped");
  a_pg_rise: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(power_good_out) |-> !main_fault_out && !aux_fault_out
    && soft_start_code == SS_CODE_TOP) else $error("power good rose too early");
  a_pg_aux: assert property (@(posedge ref_clk) disable iff (!resetn)
    aux_fault_out |-> ##2 !power_good_out) else $error("power good with aux fault");
  a_req_off: assert property (@(posedge ref_clk) disable iff (!resetn)
    hi_r >= PSON_DEB + PSON_DLY + 4 |-> main_fault_out) else $error("main not released");
  a_main_fault_out_on: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(main_fault_out) |-> lo_r >= PSON_DEB + PSON_DLY - 2) else $error("early start");
  a_ov_trip: assert property (@(posedge ref_clk) disable iff (!resetn)
    ov_r >= 20'd64 |-> main_fault_out) else $error("main overvoltage not latched");
  a_aux_ov: assert property (@(posedge ref_clk) disable iff (!resetn)
    ao_r >= 20'd64 |-> aux_fault_out) else $error("aux overvoltage not latched");
  a_aux_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    aux_fault_out && run |=> aux_fault_out) else $error("aux fault dropped");
endmodule
bind sfts_top sfts_monitor #(.PSON_DLY(PSON_DLY), .PSON_DEB(PSON_DEB)) u_sfts_monitor (
  .ref_clk, .resetn, .clk_en, .supply_ok_in, .cmp_in, .supply_on_request,
  .power_good_out, .main_fault_out, .aux_fault_out, .soft_start_code);
`default_nettype wire

//--- sfts_host_model.sv
// motherboard model driving the supply-on request line
// assumes the bench calls its tasks; levels change just after an edge
`timescale 1ns/1ps
`default_nettype none
module sfts_host_model #(
  parameter int unsigned HOLD = 100
) (
  // timebase
  input wire logic ref_clk,
  // request, low asks for power; pulled up when idle
  output logic     supply_on_request
);
  initial supply_on_request = 1'b1;
  // a new level is held past the debounce time before anything else
  task automatic set_level(input logic lvl);
    @(posedge ref_clk);
    #1;
    supply_on_request = lvl;
    repeat (HOLD) @(posedge ref_clk);
    #1;
  endtask
  // deliberately short pulse that must be ignored
  task automatic glitch(input int k);
    @(posedge ref_clk);
    #1;
    supply_on_request = ~supply_on_request;
    repeat (k) @(posedge ref_clk);
    #1;
    supply_on_request = ~supply_on_request;
  endtask
endmodule
`default_nettype wire

//--- supply_fault_timing_supervisor_tb.sv
// self-checking bench of the supply fault timing supervisor
// assumes shortened counts, the soft-start step included, so the run stays short
`timescale 1ns/1ps
`default_nettype none
module supply_fault_timing_supervisor_tb;
  import sfts_pkg::*;
  localparam int DEB = 80, DLY = 30, PGD = 100, RTY = 200, STP = 5;
  localparam int RAMP = SS_STEPS * STP;  // full staircase, cycles
  logic            ref_clk, resetn, clk_en, supply_ok_in, bounce_mode_in, mains_sense_in;
  sfts_cmp_t       cmp_in;
  logic            supply_on_request, power_good_out, main_fault_out, aux_fault_out;
  logic [SS_W-1:0] soft_start_code;
  int              mismatches, cmp_count, cycles, n;
  // aux cases: settle time, comparator pattern, length, expected fault
  typedef struct {int pre; sfts_cmp_t cmp; int len; logic exp;} sfts_row_t;
  sfts_row_t rows [5] = '{'{150, 5'h02, 40, 1'b0}, '{150, 5'h02, 70, 1'b1},
    '{0, 5'h01, 60, 1'b0}, '{150, 5'h01, 40, 1'b0}, '{150, 5'h01, 60, 1'b1}};
  sfts_top #(.UV5_DEB(50), .BLANK(100), .PG_DELAY(PGD), .PSON_DLY(DLY), .PSON_DEB(DEB),
    .RETRY(RTY), .SS_STEP(STP)) u_sfts_top (.ref_clk, .resetn, .clk_en, .supply_ok_in,
    .bounce_mode_in, .cmp_in, .mains_sense_in, .supply_on_request, .power_good_out,
    .main_fault_out, .aux_fault_out, .soft_start_code);
  sfts_host_model #(.HOLD(DEB + 20)) u_sfts_host_model (.ref_clk, .supply_on_request);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // hang guard, well above the expected run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input logic seen, input logic exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %b want %b", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // supply dips below threshold, restarting every timer
  task automatic restart();
    supply_ok_in = 1'b0;
    tick(2);
    supply_ok_in = 1'b1;
  endtask
  task automatic wait_main(input logic lvl, input int lim);
    for (n = 0; n < lim && main_fault_out !== lvl; n++) tick(1);
    chk(main_fault_out, lvl);
  endtask
  // ramp must take 64 steps of STP cycles
  task automatic wait_top();
    for (n = 0; n < RAMP + 50 && soft_start_code !== SS_CODE_TOP; n++) tick(1);
    chk(n >= RAMP - 2 && n <= RAMP + 2, 1'b1);
  endtask
  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {resetn, bounce_mode_in, cmp_in} = '0;
    {clk_en, supply_ok_in, mains_sense_in} = 3'b111;
    tick(5);
    chk(main_fault_out & ~aux_fault_out & ~power_good_out, 1'b1);
    resetn = 1'b1;
    foreach (rows[r]) begin
      restart();
      tick(rows[r].pre);
      cmp_in = rows[r].cmp;
      tick(rows[r].len);
      cmp_in = '0;
      tick(3);
      chk(aux_fault_out, rows[r].exp);
    end
    restart();
    u_sfts_host_model.set_level(1'b0);
    tick(4);
    chk(main_fault_out, 1'b1);
    wait_main(1'b0, 30);
    wait_top();
    tick(PGD - 5);
    chk(power_good_out, 1'b0);
    tick(20);
    chk(power_good_out, 1'b1);
    // a low enable freezes every timer, so a long overvoltage is not counted
    clk_en = 1'b0;
    cmp_in = 5'h10;
    tick(70);
    chk(main_fault_out | ~power_good_out, 1'b0);
    cmp_in = '0;
    clk_en = 1'b1;
    cmp_in = 5'h10;
    tick(40);
    cmp_in = '0;
    tick(5);
    chk(main_fault_out, 1'b0);
    cmp_in = 5'h10;
    tick(70);
    cmp_in = '0;
    chk(main_fault_out & ~power_good_out, 1'b1);
    tick(RTY + 50);
    chk(main_fault_out, 1'b1);
    bounce_mode_in = 1'b1;
    restart();
    wait_main(1'b0, DEB + DLY + 30);
    wait_top();
    // mains sense drop restarts the main blanking, hiding both undervoltages
    mains_sense_in = 1'b0;
    tick(1);
    mains_sense_in = 1'b1;
    cmp_in = 5'h0C;
    tick(70);
    cmp_in = '0;
    chk(main_fault_out, 1'b0);
    cmp_in = 5'h08;
    tick(70);
    cmp_in = '0;
    chk(main_fault_out, 1'b1);
    wait_main(1'b0, RTY + 100);
    // 5 V and 3.3 V undervoltage uses the shortened 50-cycle debounce
    cmp_in = 5'h04;
    tick(45);
    chk(main_fault_out, 1'b0);
    tick(10);
    chk(main_fault_out, 1'b1);
    cmp_in = '0;
    wait_main(1'b0, RTY + 100);
    u_sfts_host_model.glitch(40);
    tick(DEB + DLY + 10);
    chk(main_fault_out, 1'b0);
    u_sfts_host_model.set_level(1'b1);
    chk(main_fault_out, 1'b0);
    wait_main(1'b1, 20);
    conclude();
  end
endmodule
`default_nettype wire
